/* verilog/phy_mac_side_fifo_status_ctrl.sv */
// mac-side interrupt, fifo status, rx error capture and control two registers
// assumes one ahb-lite master, inputs synchronous to hclk, hresetn async low
//
// The implementer's own choice: the AHB-Lite register port.
`include "phy_mac_side_defs.svh"

module phy_mac_side_fifo_status_ctrl
	import phy_mac_side_pkg::*;
(
	input  wire logic                          hclk,         // bus clock
	input  wire logic                          hresetn,      // async reset, low
	input  wire logic                          hsel,         // slave select
	input  wire logic [31:0]                   haddr,        // byte address
	input  wire logic [1:0]                    htrans,       // transfer type
	input  wire logic                          hwrite,       // write when high
	input  wire logic [2:0]                    hsize,        // transfer size
	input  wire logic                          hready,       // bus ready in
	input  wire logic [31:0]                   hwdata,       // write data
	output logic      [31:0]                   hrdata,       // read data
	output logic                               hreadyout,    // slave ready
	output logic                               hresp,        // always okay
	input  wire logic                          soft_reset,   // phy software reset pulse
	input  wire phy_mac_side_pkg::fifo_event_t fifo_events,  // copper fifo events
	input  wire phy_mac_side_pkg::gmii_rx_t    rx_in,        // received byte stream
	output logic                               irq,          // level interrupt
	output logic                               line_loopback,// copper line loopback
	output logic                               block_carrier_ext, // block carrier ext
	output logic      [2:0]                    default_speed // applied link-down speed
);
	import phy_mac_side_pkg::*;

	localparam int DEPTH = `CAP_DEPTH;

	function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
		hit = (a[31:2] == {22'h000000, idx});
	endfunction

	// bus address phase capture
	logic        wr_pend_reg, wr_pend_next;
	logic        rd_pend_reg, rd_pend_next;
	logic [31:0] addr_reg,    addr_next;
	logic [31:0] hrdata_reg,  hrdata_next;
	// register state
	logic [15:0] irq_en_reg,  irq_en_next;
	logic [15:0] status_reg,  status_next;
	logic [15:0] ctrl_reg,    ctrl_next;
	logic [2:0]  speed_reg,   speed_next;
	logic        irq_reg,     irq_next;
	// capture state
	cap_state_t  cap_st_reg,  cap_st_next;
	gmii_rx_t    hist_reg  [DEPTH];
	gmii_rx_t    hist_next [DEPTH];
	gmii_rx_t    held_reg  [DEPTH];
	gmii_rx_t    held_next [DEPTH];
	logic [1:0]  byte_reg,    byte_next;

	logic        addr_ok;
	logic        rd_status;
	logic        rd_capture;
	logic [15:0] ev_vec;
	logic [15:0] cap_word;

	assign addr_ok = hsel && hready && htrans[1];
	assign rd_status = rd_pend_reg && hit(addr_reg, `IDX_EVENT_STATUS);
	assign rd_capture = rd_pend_reg && hit(addr_reg, `IDX_RXERR_CAPTURE);

	always_comb
	begin
		ev_vec = 16'h0000;
		ev_vec[`BIT_FIFO_ERR] = fifo_events.fifo_err;
		ev_vec[`BIT_IDLE_INS] = fifo_events.idle_ins;
		ev_vec[`BIT_IDLE_DEL] = fifo_events.idle_del;
	end

	always_comb
	begin
		cap_word = 16'h0000;
		if (cap_st_reg == CAP_HOLDING)
		begin
			cap_word[`CAP_VALID_BIT] = 1'b1;
			cap_word[`CAP_BYTE_HI:`CAP_BYTE_LO] = byte_reg;
			cap_word[`CAP_RXER_BIT] = held_reg[byte_reg].rx_er;
			cap_word[`CAP_RXDV_BIT] = held_reg[byte_reg].rx_dv;
			cap_word[7:0] = held_reg[byte_reg].rxd;
		end
	end

	// bus slave: zero wait states, unmapped reads give zero, writes ignored
	always_comb
	begin
		wr_pend_next = addr_ok && hwrite;
		rd_pend_next = addr_ok && !hwrite;
		addr_next = addr_ok ? haddr : addr_reg;
		hrdata_next = 32'h00000000;
		if (addr_ok && !hwrite)
		begin
			if (hit(haddr, `IDX_IRQ_ENABLE))
				hrdata_next = {16'h0000, irq_en_reg};
			else if (hit(haddr, `IDX_EVENT_STATUS))
				hrdata_next = {16'h0000, status_reg | ev_vec};
			else if (hit(haddr, `IDX_RXERR_CAPTURE))
				hrdata_next = {16'h0000, cap_word};
			else if (hit(haddr, `IDX_MAC_CTRL_TWO))
				hrdata_next = {16'h0000, ctrl_reg};
		end
	end

	// registers, soft reset applies per-field retain, clear or default reload
	always_comb
	begin
		irq_en_next = irq_en_reg;
		ctrl_next = ctrl_reg;
		speed_next = speed_reg;
		status_next = status_reg;
		if (wr_pend_reg && hit(addr_reg, `IDX_IRQ_ENABLE))
			irq_en_next = hwdata[15:0] & `EVENT_MASK;
		if (wr_pend_reg && hit(addr_reg, `IDX_MAC_CTRL_TWO))
			ctrl_next = hwdata[15:0] & `CTL_WRITE_MASK;
		// set wins over the clear-on-read in the same cycle
		if (rd_status)
			status_next = ev_vec;
		else
			status_next = status_reg | ev_vec;
		if (soft_reset)
		begin
			status_next = 16'h0000;
			// loopback and bits 11:7 clear; 13:12, 6 reload defaults; 5:3 and speed bits 2:0 keep their value
			ctrl_next = (ctrl_next & 16'h0038) | 16'h1040 | {13'h0000, ctrl_next[2:0]};
			speed_next = ctrl_next[`CTL_SPEED_HI:`CTL_SPEED_LO];
		end
		irq_next = |(status_next & irq_en_next);
	end

	// capture: history shifts every cycle; held copy freezes on rx error while armed
	always_comb
	begin
		cap_st_next = cap_st_reg;
		byte_next = byte_reg;
		for (int i = 0; i < DEPTH; i++)
		begin
			hist_next[i] = hist_reg[i];
			held_next[i] = held_reg[i];
		end
		for (int i = 0; i < DEPTH - 1; i++)
			hist_next[i] = hist_reg[i + 1];
		hist_next[DEPTH - 1] = rx_in;
		case (cap_st_reg)
			CAP_ARMED:
			begin
				if (rx_in.rx_er)
				begin
					for (int i = 0; i < DEPTH; i++)
						held_next[i] = hist_reg[i];
					byte_next = 2'b00;
					cap_st_next = CAP_HOLDING;
				end
			end
			CAP_HOLDING:
			begin
				if (rd_capture)
				begin
					byte_next = byte_reg + 2'b01;
					if (byte_reg == 2'b11)
						cap_st_next = CAP_ARMED;
				end
			end
			default: cap_st_next = CAP_ARMED;
		endcase
		if (soft_reset)
		begin
			cap_st_next = CAP_ARMED;
			byte_next = 2'b00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 32'h00000000;
			hrdata_reg <= 32'h00000000;
			irq_en_reg <= 16'h0000;
			status_reg <= 16'h0000;
			ctrl_reg <= `CTL_RESET_VALUE;
			speed_reg <= `SPEED_RESET;
			irq_reg <= 1'b0;
			cap_st_reg <= CAP_ARMED;
			byte_reg <= 2'b00;
			for (int i = 0; i < DEPTH; i++)
			begin
				hist_reg[i] <= '0;
				held_reg[i] <= '0;
			end
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			addr_reg <= addr_next;
			hrdata_reg <= hrdata_next;
			irq_en_reg <= irq_en_next;
			status_reg <= status_next;
			ctrl_reg <= ctrl_next;
			speed_reg <= speed_next;
			irq_reg <= irq_next;
			cap_st_reg <= cap_st_next;
			byte_reg <= byte_next;
			for (int i = 0; i < DEPTH; i++)
			begin
				hist_reg[i] <= hist_next[i];
				held_reg[i] <= held_next[i];
			end
		end
	end

	// control bits act at once; speed waits for a software reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			line_loopback <= 1'b0;
			block_carrier_ext <= 1'b0;
		end
		else
		begin
			line_loopback <= ctrl_next[`CTL_LOOPBACK_BIT];
			block_carrier_ext <= ctrl_next[`CTL_BLOCK_CE_BIT];
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = irq_reg;
	assign default_speed = speed_reg;
endmodule

/* shared/phy_mac_side_defs.svh */
// register offsets, field positions, reset values for the mac-side register bank
// assumes inclusion by bare name from the design
`ifndef PHY_MAC_SIDE_DEFS_SVH
`define PHY_MAC_SIDE_DEFS_SVH

// printed offsets are register indices; byte address is index times four
`define IDX_IRQ_ENABLE     8'h12
`define IDX_EVENT_STATUS   8'h13
`define IDX_RXERR_CAPTURE  8'h14
`define IDX_MAC_CTRL_TWO   8'h15

`define BIT_FIFO_ERR       7
`define BIT_IDLE_INS       3
`define BIT_IDLE_DEL       2
`define EVENT_MASK         16'h008C

`define CAP_VALID_BIT      15
`define CAP_BYTE_HI        13
`define CAP_BYTE_LO        12
`define CAP_RXER_BIT       9
`define CAP_RXDV_BIT       8
`define CAP_DEPTH          4

`define CTL_LOOPBACK_BIT   14
`define CTL_BLOCK_CE_BIT   3
`define CTL_SPEED_HI       2
`define CTL_SPEED_LO       0
`define CTL_RESET_VALUE    16'h1046
`define CTL_WRITE_MASK     16'h7FFF
`define SPEED_RESET        3'h6

`endif

/* shared/phy_mac_side_pkg.sv */
// types for the mac-side register bank
// assumes the defs header is on the include path
package phy_mac_side_pkg;
	typedef struct packed {
		logic       fifo_err;  // copper fifo over/underflow this cycle
		logic       idle_ins;  // idle inserted this cycle
		logic       idle_del;  // idle deleted this cycle
	} fifo_event_t;

	typedef struct packed {
		logic       rx_er;
		logic       rx_dv;
		logic [7:0] rxd;
	} gmii_rx_t;

	typedef enum logic [1:0] {
		CAP_ARMED   = 2'b00,
		CAP_HOLDING = 2'b01
	} cap_state_t;
endpackage

/* testbench/phy_mac_side_fifo_status_ctrl_sva.sv */
// port assertions for the mac-side register bank
// assumes one hclk domain, zero-wait slave, bound into every instance
module mac_side_chk
	import phy_mac_side_pkg::*;
(
	input wire logic                          hclk,              // clock
	input wire logic                          hresetn,           // reset, low
	input wire logic                          hsel,              // select
	input wire logic [31:0]                   haddr,             // address
	input wire logic [1:0]                    htrans,            // transfer type
	input wire logic                          hwrite,            // write
	input wire logic                          hready,            // bus ready
	input wire logic [31:0]                   hwdata,            // write data
	input wire logic [31:0]                   hrdata,            // read data
	input wire logic                          hreadyout,         // slave ready
	input wire logic                          hresp,             // response
	input wire logic                          soft_reset,        // sw reset
	input wire phy_mac_side_pkg::fifo_event_t fifo_events,       // events
	input wire logic                          irq,               // interrupt
	input wire logic                          line_loopback,     // loopback
	input wire logic                          block_carrier_ext, // block ext
	input wire logic [2:0]                    default_speed      // speed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        wr_q;
	logic        rd_q;
	logic [31:0] a_q;
	logic        take;
	assign take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wr_q <= 1'h0;
			rd_q <= 1'h0;
			a_q <= 32'h0;
		end
		else
		begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			a_q <= haddr;
		end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
	idle_data_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("data outside read");
	enable_bits_a: assert property (rd_q && a_q == 32'h48 |-> (hrdata & ~32'h8C) == 32'h0)
		else $error("enable reserved bits set");
	status_bits_a: assert property (rd_q && a_q == 32'h4C |-> (hrdata & ~32'h8C) == 32'h0)
		else $error("status reserved bits set");
	capture_form_a: assert property (rd_q && a_q == 32'h50 |->
		(hrdata & 32'hFFFF4C00) == 32'h0 && (hrdata[15] || hrdata == 32'h0)) else $error("bad capture");
	loop_follow_a: assert property (wr_q && a_q == 32'h54 && !soft_reset |=>
		line_loopback == $past(hwdata[14])) else $error("loopback not written");
	carrier_follow_a: assert property (wr_q && a_q == 32'h54 |=>
		block_carrier_ext == $past(hwdata[3])) else $error("carrier block not written");
	speed_hold_a: assert property (!$stable(default_speed) |-> $past(soft_reset))
		else $error("speed changed without soft reset");
	// irq is registered from the next status, so its cause sits one sample back
	irq_rise_a: assert property ($rose(irq) |-> $past(|fifo_events, 1) || $past(wr_q, 1))
		else $error("interrupt without cause");
	irq_fall_a: assert property ($fell(irq) |->
		$past(rd_q, 1) || $past(wr_q, 1) || $past(soft_reset, 1)) else $error("interrupt dropped");
endmodule

bind phy_mac_side_fifo_status_ctrl mac_side_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .soft_reset, .fifo_events, .irq,
	.line_loopback, .block_carrier_ext, .default_speed);

/* testbench/mac_far_model.sv */
// far side: copper fifo events and received byte stream
// assumes tasks are called by the bench just after a rising edge
module mac_far_model
	import phy_mac_side_pkg::*;
(
	input  wire logic                     hclk,        // clock
	output phy_mac_side_pkg::fifo_event_t fifo_events, // event pulses
	output phy_mac_side_pkg::gmii_rx_t    rx_in        // byte stream
);
	timeunit 1ns;
	timeprecision 1ps;
	gmii_rx_t hist [4];
	gmii_rx_t cap [4];
	logic     err_req = 1'h0;
	initial
	begin
		fifo_events = '0;
		rx_in = '0;
	end
	// hist holds the bytes the block sampled, oldest first
	always @(posedge hclk)
	begin
		hist <= '{hist[1], hist[2], hist[3], rx_in};
		rx_in <= {err_req, 1'h1, 8'($urandom)};
	end
	task automatic pulse(input fifo_event_t e);
		@(posedge hclk);
		fifo_events <= e;
		@(posedge hclk);
		fifo_events <= '0;
	endtask
	// one error byte; cap keeps the four bytes before it
	task automatic raise_err();
		@(posedge hclk);
		err_req <= 1'h1;
		@(posedge hclk);
		err_req <= 1'h0;
		#1;
		cap = hist;
	endtask
endmodule

/* testbench/tb_phy_mac_side_fifo_status_ctrl.sv */
// self-checking bench for the mac-side register bank
// assumes the far model and the bound checker are compiled alongside
module tb_phy_mac_side_fifo_status_ctrl
	import phy_mac_side_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        soft_reset = 1'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        line_loopback;
	logic        block_carrier_ext;
	logic [2:0]  default_speed;
	fifo_event_t fifo_events;
	gmii_rx_t    rx_in;
	int          fails = 0;
	int          checked = 0;
	logic [31:0] rv;
	logic [31:0] r;
	always #12.5 hclk = ~hclk;
	phy_mac_side_fifo_status_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .soft_reset, .fifo_events,
		.rx_in, .irq, .line_loopback, .block_carrier_ext, .default_speed);
	mac_far_model far (.hclk, .fifo_events, .rx_in);
	function automatic logic [31:0] ev_bit(input int i);
		return i == 0 ? 32'h80 : (i == 1 ? 32'h8 : 32'h4);
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do
			@(posedge hclk);
		while (hreadyout !== 1'h1 && ++n < 50);
		if (hreadyout !== 1'h1)
		begin
			fails++;
			end_of_test();
		end
	endtask
	// one single transfer; read data lands in rv
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		wait_rdy();
		rv = hrdata;
	endtask
	initial
	begin
		r = $urandom(95);
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'h0, 32'h48 + 32'(4 * i), 32'h0);
			chk("reset value", i == 3 ? 32'h1046 : 32'h0, rv);
		end
		repeat (4)
		begin
			r = $urandom;
			xfer(1'h1, 32'h48, r);
			xfer(1'h0, 32'h48, 32'h0);
			chk("enable", r & 32'h8C, rv);
		end
		xfer(1'h1, 32'h54, 32'hFFFFFFFF);
		xfer(1'h0, 32'h54, 32'h0);
		chk("control", 32'h7FFF, rv);
		chk("loopback", 32'h1, 32'(line_loopback));
		chk("speed held", 32'h6, 32'(default_speed));
		for (int c = 4; c < 7; c++)
		begin
			r = $urandom;
			xfer(1'h1, 32'h54, {r[31:3], 3'(c)});
			@(posedge hclk);
			soft_reset <= 1'h1;
			@(posedge hclk);
			soft_reset <= 1'h0;
			@(posedge hclk);
			chk("speed", 32'(c), 32'(default_speed));
			chk("block", 32'(r[3]), 32'(block_carrier_ext));
			xfer(1'h0, 32'h54, 32'h0);
			chk("control after soft reset", (r & 32'h38) | 32'(c) | 32'h1040, rv);
		end
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 3; i++)
			begin
				xfer(1'h1, 32'h48, m ? ev_bit(i) : 32'h0);
				far.pulse(fifo_event_t'(3'h4 >> i));
				repeat (3) @(posedge hclk);
				chk("irq", 32'(m), 32'(irq));
				xfer(1'h0, 32'h4C, 32'h0);
				chk("status", ev_bit(i), rv);
				xfer(1'h0, 32'h4C, 32'h0);
				chk("status cleared", 32'h0, rv);
			end
		far.raise_err();
		repeat (2) @(posedge hclk);
		for (int k = 0; k < 4; k++)
		begin
			xfer(1'h0, 32'h50, 32'h0);
			chk("capture", {16'h0, 2'h2, 2'(k), 2'h0, far.cap[k]}, rv);
		end
		xfer(1'h0, 32'h50, 32'h0);
		chk("capture rearmed", 32'h0, rv);
		end_of_test();
	end
endmodule
